// file: dv/bws_chk.sv
// Purpose: Port assertions for bws_top
// Assumes: Three edges from input to lamp, four via state_r or emergency
// Notes:   Checks wait until the reset copy is free
`timescale 1ns/10ps
`default_nettype none
module bws_chk
    import bws_pkg::*;
#(
    parameter int BLINK_HALF = 4
) (
    input wire logic         MCLK,
    input wire logic         NRST,
    input wire logic         IGN_ON,
    input wire bws_fault_s   FAULT,
    input wire bws_trailer_s TRAILER,
    input wire bws_brake_s   BRAKE,
    input wire logic [7:0]   SPEED,
    input wire logic [7:0]   DECEL,
    input wire logic [7:0]   DECEL_PRED,
    input wire bws_out_s     LAMPS
);
    logic [3:0] age_r;
    logic [3:0] age_nxt;
    logic       ok;
    logic       quiet;
    assign ok = age_r == 4'hf;
    assign quiet = !(BRAKE.driver_brake || BRAKE.auto_brake || BRAKE.endur_elec || BRAKE.endur_other
                     || (TRAILER.stop_msg && TRAILER.present));
    always_comb age_nxt = ok ? age_r : age_r + 4'h1;
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) age_r <= 4'h0;
        else age_r <= age_nxt;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // ****************************************
    // Assertions
    // ****************************************
    red_fault_a: assert property ((ok && FAULT.red_fault && IGN_ON) [*5] |-> LAMPS.red)
        else $error("red lamp off");
    yel_steady_a: assert property ((ok && FAULT.yel_fault && IGN_ON) [*5] |-> LAMPS.yellow)
        else $error("yellow lamp not steady");
    trl_pass_a: assert property ((ok && TRAILER.present && TRAILER.pin_defect && IGN_ON) [*5]
        |-> LAMPS.trl_yellow) else $error("trailer lamp off");
    trl_absent_a: assert property (ok && LAMPS.trl_yellow |-> $past(TRAILER.present, 3))
        else $error("trailer lamp without trailer");
    stop_drv_a: assert property ((ok && BRAKE.driver_brake && !BRAKE.selective) [*4] |-> LAMPS.stop)
        else $error("stop lamp missing");
    stop_quiet_a: assert property ((ok && quiet) [*5] |-> !LAMPS.stop)
        else $error("stop lamp without source");
    emg_off_a: assert property ((ok && DECEL < EMG_OFF && DECEL_PRED < EMG_OFF) [*4] |-> !LAMPS.emergency)
        else $error("emergency held");
    emg_src_a: assert property (ok && $rose(LAMPS.emergency)
        |-> $past(BRAKE.driver_brake || BRAKE.auto_brake, 4)) else $error("emergency without braking");
    emg_thr_a: assert property (ok && $rose(LAMPS.emergency) && !$past(BRAKE.use_predict, 4)
        && !$past(BRAKE.abs_cycling, 4) |-> $past(DECEL, 4) >= ($past(BRAKE.light_cat, 4) ? EMG_ON_LIGHT
        : EMG_ON_HEAVY)) else $error("emergency below threshold");
    ign_off_a: assert property ((ok && !IGN_ON) [*5] |-> !LAMPS.red && !LAMPS.yellow && !LAMPS.trl_yellow)
        else $error("warning with ignition off");
    blink_stop_a: assert property ((ok && SPEED > BLINK_SPD_MAX && !FAULT.yel_fault && IGN_ON) [*6]
        |-> !$rose(LAMPS.yellow)) else $error("yellow blinking while moving");
endmodule // bws_chk
`default_nettype wire

// file: dv/bws_trl.sv
// Purpose: Trailer end of the control line
// Assumes: Commands come from the bench
// Notes:   Released lines toggle every cycle
`timescale 1ns/10ps
`default_nettype none
module bws_trl
    import bws_pkg::*;
(
    input  wire logic      MCLK,
    input  wire logic      coupled,
    input  wire logic      defect,
    input  wire logic      fail,
    input  wire logic      stop_req,
    output var bws_trailer_s trl
);
    logic tog_r = 1'b0;
    always_ff @(posedge MCLK) tog_r <= !tog_r;
    always_comb begin
        trl.present    = coupled;
        trl.pin_defect = coupled ? defect : tog_r;
        trl.red_msg    = coupled ? fail : tog_r;
        trl.stop_msg   = coupled ? stop_req : !tog_r;
    end
endmodule // bws_trl
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for bws_top
// Assumes: Three edges from input to lamp, four via state_r or emergency
// Notes:   Blink half period cut to 4 cycles
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %0t line %0d", $time, `__LINE__); end end
module tb;
    import bws_pkg::*;
    logic         MCLK = 1'b0;
    logic         NRST = 1'b0;
    logic         ign  = 1'b0;
    bws_fault_s   flt  = '0;
    bws_brake_s   brk  = '0;
    logic [7:0]   spd  = 8'h00;
    logic [7:0]   dec  = 8'h00;
    logic [7:0]   decp = 8'h00;
    logic         cpl  = 1'b0;
    logic         dfc  = 1'b0;
    logic         fl   = 1'b0;
    logic         sr   = 1'b0;
    bws_trailer_s trl;
    bws_out_s     lamps;
    int           checks = 0;
    int           miscompares = 0;
    int           cycles = 0;
    bws_top #(.BLINK_HALF(4)) dut (.MCLK(MCLK), .NRST(NRST), .IGN_ON(ign), .FAULT(flt), .TRAILER(trl),
        .BRAKE(brk), .SPEED(spd), .DECEL(dec), .DECEL_PRED(decp), .LAMPS(lamps));
    bws_trl ptr (.MCLK(MCLK), .coupled(cpl), .defect(dfc), .fail(fl), .stop_req(sr), .trl(trl));
    initial forever #2.5 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    task finish_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    task t_power;
        int seen;
        seen = 0;
        ign = 1'b1;
        repeat (10) begin
            cyc(1);
            if (lamps.red === 1'b1 && lamps.yellow === 1'b1) seen = 1;
        end
        `CHK(seen, 1)
        `CHK(lamps.red, 1'b0)
    endtask
    task t_fault;
        flt.red_fault = 1'b1;
        flt.yel_fault = 1'b1;
        cyc(5);
        repeat (12) begin
            `CHK({lamps.red, lamps.yellow}, 2'b11)
            cyc(1);
        end
        flt = '0;
        cyc(5);
    endtask
    task t_trl;
        cpl = 1'b1;
        dfc = 1'b1;
        cyc(5);
        `CHK(lamps.trl_yellow, 1'b1)
        fl = 1'b1;
        cyc(6);
        `CHK({lamps.red, lamps.trl_red}, 2'b11)
        {cpl, dfc, fl} = 3'h0;
        cyc(5);
        repeat (8) begin
            `CHK(lamps.trl_yellow, 1'b0)
            cyc(1);
        end
    endtask
    task stp(input bws_brake_s b, input logic [7:0] d, input logic e);
        brk = b;
        dec = d;
        cyc(5);
        `CHK(lamps.stop, e)
        brk = '0;
        dec = 8'h00;
        cyc(5);
    endtask
    task t_stop;
        stp(8'h80, 8'h00, 1'b1);
        stp(8'h20, 8'h14, 1'b0);
        stp(8'h40, 8'h07, 1'b1);
        stp(8'h10, 8'h0b, 1'b1);
        stp(8'h00, 8'h1e, 1'b0);
        {cpl, sr} = 2'h3;
        cyc(5);
        `CHK(lamps.stop, 1'b1)
        {cpl, sr} = 2'h0;
        cyc(5);
    endtask
    task emg(input bws_brake_s b, input logic [7:0] s, input logic [7:0] d, input logic [7:0] p, input logic e);
        brk = b;
        spd = s;
        dec = d;
        decp = p;
        cyc(6);
        `CHK(lamps.emergency, e)
        brk = b & 8'hfb;
        dec = 8'h18;
        decp = 8'h00;
        cyc(4);
        `CHK(lamps.emergency, 1'b0)
        {brk, spd, dec} = 24'h0;
        cyc(4);
    endtask
    task t_emg;
        emg(8'h80, 8'h00, 8'h28, 8'h00, 1'b1);
        emg(8'h80, 8'h00, 8'h27, 8'h00, 1'b0);
        emg(8'h82, 8'h00, 8'h3b, 8'h00, 1'b0);
        emg(8'h82, 8'h00, 8'h3c, 8'h00, 1'b1);
        emg(8'h00, 8'h00, 8'h50, 8'h00, 1'b0);
        emg(8'h81, 8'h00, 8'h19, 8'h28, 1'b1);
        emg(8'h84, 8'h33, 8'h1e, 8'h00, 1'b1);
    endtask
    task t_info;
        int ones;
        ones = 0;
        flt.info_req = 1'b1;
        cyc(5);
        repeat (20) begin
            cyc(1);
            if (lamps.yellow === 1'b1) ones++;
        end
        `CHK(ones > 4 && ones < 16, 1'b1)
        spd = 8'h05;
        cyc(5);
        repeat (6) begin
            `CHK(lamps.yellow, 1'b0)
            cyc(1);
        end
        spd = 8'h00;
        cyc(8);
        spd = 8'h0b;
        cyc(5);
        repeat (12) begin
            `CHK(lamps.yellow, 1'b0)
            cyc(1);
        end
        flt = '0;
        spd = 8'h00;
    endtask
    task t_motion;
        spd = 8'h1e;
        flt.motion_fault = 1'b1;
        cyc(6);
        flt = '0;
        spd = 8'h00;
        cyc(6);
        `CHK(lamps.red | lamps.yellow, 1'b1)
        ign = 1'b0;
        cyc(6);
        `CHK(lamps.red | lamps.yellow, 1'b0)
        ign = 1'b1;
        cyc(12);
        `CHK(lamps.red | lamps.yellow, 1'b1)
        NRST = 1'b0;
        cyc(2);
        `CHK(lamps, 6'h00)
        NRST = 1'b1;
        cyc(20);
    endtask
    initial begin
        cyc(10);
        NRST = 1'b1;
        cyc(3);
        t_power();
        t_fault();
        t_trl();
        t_stop();
        t_info();
        t_emg();
        t_motion();
        finish_test();
    end
endmodule // tb
bind bws_top bws_chk #(.BLINK_HALF(BLINK_HALF)) chk (.MCLK(MCLK), .NRST(NRST), .IGN_ON(IGN_ON), .FAULT(FAULT),
    .TRAILER(TRAILER), .BRAKE(BRAKE), .SPEED(SPEED), .DECEL(DECEL), .DECEL_PRED(DECEL_PRED), .LAMPS(LAMPS));
`default_nettype wire

// file: hdl/bws_top.sv
// Purpose: Brake warning lamps, stop lamp request and emergency signal
// Assumes: All inputs asynchronous to MCLK; power-up asserts NRST
// Notes:   Engine braking and throttle-off regeneration never reach the
//          brake inputs, so they cannot request stop lamps
`timescale 1ns/10ps
`default_nettype none
// How it works
// [RULE_01] Red lamp on for red-class faults
// [RULE_02] Yellow lamp on for other electric defects
// [RULE_03] Trailer defect line passed straight to lamp
// [RULE_04] Trailer yellow off without coupled trailer
// [RULE_05] Trailer failure message lights red too
// [RULE_06] Warnings shown before braking control actuated
// [RULE_07] Warnings held while fault and ignition on
// [RULE_08] Specified fault warnings steady, never blinking
// [RULE_09] Lamps on at power-up, checked when stationary
// [RULE_10] Motion-only faults latched, shown each start-up
// [RULE_11] Yellow blinks info only stationary, after check
// [RULE_12] Info blinking stops above 10 km/h
// [RULE_13] Driver braking requests stop lamps
// [RULE_14] Endurance brake requests above 1.0 m/s2
// [RULE_15] Engine braking alone never lights stops
// [RULE_16] Auto braking lights stops from 0.7 m/s2
// [RULE_17] Selective braking gives no stop lamps
// [RULE_18] Trailer stop message requests stop lamps
// [RULE_19] Throttle-off regeneration gives no stop lamps
// [RULE_20] Emergency on only by braking above threshold
// [RULE_21] Emergency off below 2.5 m/s2
// [RULE_22] Predicted decel or anti-lock alternative sources
// [RULE_23] Ignition off clears warnings, keeps latch
module bws_top #(
    parameter int BLINK_HALF = bws_pkg::BLINK_HALF_CYC
) (
    input  wire logic                        MCLK,
    input  wire logic                        NRST,
    input  wire logic                        IGN_ON,
    input  wire bws_pkg::bws_fault_s         FAULT,
    input  wire bws_pkg::bws_trailer_s       TRAILER,
    input  wire bws_pkg::bws_brake_s         BRAKE,
    input  wire logic [bws_pkg::SPD_W-1:0]   SPEED,
    input  wire logic [bws_pkg::DEC_W-1:0]   DECEL,
    input  wire logic [bws_pkg::DEC_W-1:0]   DECEL_PRED,
    output var bws_pkg::bws_out_s            LAMPS
);
    import bws_pkg::*;

    typedef enum logic [1:0] {ST_OFF, ST_CHECK, ST_RUN} bws_state_e;

    // ****************************************
    // Reset release and input synchronisers
    // ****************************************
    logic [1:0] rst_sync_r;
    logic       rst_n;
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    localparam int IN_W = 1 + $bits(bws_fault_s) + $bits(bws_trailer_s) + $bits(bws_brake_s) + SPD_W + 2 * DEC_W;
    logic [IN_W-1:0] in_s1_r;
    logic [IN_W-1:0] in_s2_r;
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            in_s1_r <= '0;
            in_s2_r <= '0;
        end else begin
            in_s1_r <= {IGN_ON, FAULT, TRAILER, BRAKE, SPEED, DECEL, DECEL_PRED};
            in_s2_r <= in_s1_r;
        end
    end

    logic                 ign;
    bws_fault_s           flt;
    bws_trailer_s         trl;
    bws_brake_s           brk;
    logic [SPD_W-1:0]     spd;
    logic [DEC_W-1:0]     dec_meas;
    logic [DEC_W-1:0]     dec_pred;
    assign {ign, flt, trl, brk, spd, dec_meas, dec_pred} = in_s2_r;

    // ****************************************
    // Warning state
    // ****************************************
    bws_state_e        state_r, state_nxt;
    logic              latch_r, latch_nxt;
    logic              clean_r, clean_nxt;
    logic [31:0]       blink_cnt_r, blink_cnt_nxt;
    logic              blink_ph_r, blink_ph_nxt;
    logic              stationary;
    logic              red_cond;
    logic              yel_cond;
    logic              info_ok;

    assign stationary = (spd == '0);
    assign red_cond   = flt.red_fault | latch_r | (trl.present & trl.red_msg);   // RULE_01 RULE_05 RULE_10
    assign yel_cond   = flt.yel_fault;                                           // RULE_02
    assign info_ok    = clean_r & flt.info_req & stationary
                        & ~yel_cond & ~red_cond;                                 // RULE_11 RULE_12

    always_comb begin
        state_nxt     = state_r;
        latch_nxt     = latch_r | flt.motion_fault;                              // RULE_10
        clean_nxt     = clean_r;
        blink_cnt_nxt = blink_cnt_r;
        blink_ph_nxt  = blink_ph_r;
        if (!stationary && !(spd <= BLINK_SPD_MAX)) begin
            clean_nxt = 1'b0;                                                    // RULE_12
        end
        unique case (state_r)
            ST_OFF: begin
                clean_nxt = 1'b0;                                                // RULE_23
                if (ign) begin
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!ign) begin
                    state_nxt = ST_OFF;
                end else if (stationary && !red_cond && !yel_cond) begin
                    state_nxt = ST_RUN;                                          // RULE_09
                    clean_nxt = 1'b1;
                end
            end
            ST_RUN: begin
                if (!ign) begin
                    state_nxt = ST_OFF;                                          // RULE_23
                end
            end
        endcase
        if (info_ok) begin
            if (blink_cnt_r >= 32'(BLINK_HALF - 1)) begin
                blink_cnt_nxt = '0;
                blink_ph_nxt  = ~blink_ph_r;
            end else begin
                blink_cnt_nxt = blink_cnt_r + 32'h1;
            end
        end else begin
            blink_cnt_nxt = '0;
            blink_ph_nxt  = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_OFF;
            latch_r     <= 1'b0;
            clean_r     <= 1'b0;
            blink_cnt_r <= '0;
            blink_ph_r  <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            latch_r     <= latch_nxt;
            clean_r     <= clean_nxt;
            blink_cnt_r <= blink_cnt_nxt;
            blink_ph_r  <= blink_ph_nxt;
        end
    end

    // ****************************************
    // Stop lamp and emergency signal
    // ****************************************
    logic              svc_brake;
    logic              stop_cond;
    logic              emg_r, emg_nxt;
    logic              emg_abs_r, emg_abs_nxt;
    logic [DEC_W-1:0]  dec_use;
    logic [DEC_W-1:0]  emg_on_thr;

    assign svc_brake  = (brk.driver_brake | brk.auto_brake) & ~brk.selective;    // RULE_17
    assign dec_use    = brk.use_predict ? dec_pred : dec_meas;                   // RULE_22
    assign emg_on_thr = brk.light_cat ? EMG_ON_LIGHT : EMG_ON_HEAVY;             // RULE_20

    assign stop_cond = (brk.driver_brake & ~brk.selective)                       // RULE_13 RULE_15 RULE_19
                     | (brk.auto_brake & ~brk.selective & (dec_meas >= STOP_DEC_AUTO)) // RULE_16
                     | (brk.endur_elec & (dec_meas > STOP_DEC_ENDUR))            // RULE_14
                     | brk.endur_other                                           // RULE_14
                     | (trl.present & trl.stop_msg);                             // RULE_18

    always_comb begin
        emg_nxt     = emg_r;
        emg_abs_nxt = emg_abs_r;
        if (!svc_brake || dec_use < EMG_OFF) begin
            emg_nxt = 1'b0;                                                      // RULE_21
        end else if (dec_use >= emg_on_thr) begin
            emg_nxt = 1'b1;                                                      // RULE_20
        end
        if (!svc_brake || !brk.abs_cycling) begin
            emg_abs_nxt = 1'b0;                                                  // RULE_22
        end else if (spd > EMG_SPD_MIN && dec_meas >= EMG_OFF) begin
            emg_abs_nxt = 1'b1;                                                  // RULE_22
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            emg_r     <= 1'b0;
            emg_abs_r <= 1'b0;
        end else begin
            emg_r     <= emg_nxt;
            emg_abs_r <= emg_abs_nxt;
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    bws_out_s out_r, out_nxt;
    logic     lamps_ok;
    assign lamps_ok = (state_r != ST_OFF);

    always_comb begin
        out_nxt            = '0;
        out_nxt.stop       = stop_cond;                                          // RULE_13 RULE_18
        out_nxt.emergency  = (emg_r | emg_abs_r) & ~(dec_meas < EMG_OFF);        // RULE_21
        if (state_r == ST_CHECK) begin
            out_nxt.red    = 1'b1;                                               // RULE_09
            out_nxt.yellow = 1'b1;                                               // RULE_09
        end else if (lamps_ok) begin
            out_nxt.red    = red_cond;                                           // RULE_01 RULE_06 RULE_07 RULE_08
            out_nxt.yellow = yel_cond | (info_ok & blink_ph_r);                  // RULE_02 RULE_08 RULE_11
        end
        out_nxt.trl_yellow = lamps_ok & trl.present & trl.pin_defect;            // RULE_03 RULE_04
        out_nxt.trl_red    = lamps_ok & trl.present & trl.red_msg;               // RULE_05
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign LAMPS = out_r;

endmodule // bws_top
`default_nettype wire

// file: inc/bws_pkg.sv
// Purpose: Shared constants and carriers for the brake warning and stop signal logic
// Assumes: Deceleration in units of 0.1 m/s2, speed in km/h
// Notes:   None
`default_nettype none
package bws_pkg;
    localparam int          DEC_W          = 8;
    localparam int          SPD_W          = 8;
    localparam logic [7:0]  STOP_DEC_ENDUR = 8'h0a;   // 1.0 m/s2
    localparam logic [7:0]  STOP_DEC_AUTO  = 8'h07;   // 0.7 m/s2
    localparam logic [7:0]  EMG_ON_LIGHT   = 8'h3c;   // 6 m/s2
    localparam logic [7:0]  EMG_ON_HEAVY   = 8'h28;   // 4 m/s2
    localparam logic [7:0]  EMG_OFF        = 8'h19;   // 2.5 m/s2
    localparam logic [7:0]  BLINK_SPD_MAX  = 8'h0a;   // 10 km/h
    localparam logic [7:0]  EMG_SPD_MIN    = 8'h32;   // 50 km/h
    localparam int          CLK_MHZ        = 200;
    localparam int          BLINK_HALF_MS  = 250;
    localparam int          BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

    typedef struct packed {
        logic red_fault;       // Own red-class fault
        logic yel_fault;       // Own yellow-class defect
        logic motion_fault;    // Fault detectable only while moving
        logic info_req;        // Non-specified information to show
    } bws_fault_s;

    typedef struct packed {
        logic present;         // Trailer coupled with control line
        logic pin_defect;      // Dedicated defect line from trailer
        logic red_msg;         // Specified failure message
        logic stop_msg;        // Stop lamp request message
    } bws_trailer_s;

    typedef struct packed {
        logic driver_brake;    // Driver service brake
        logic auto_brake;      // Automatically commanded braking
        logic selective;       // Selective braking only
        logic endur_elec;      // Electronically signalled endurance brake
        logic endur_other;     // Other endurance brake
        logic abs_cycling;     // Anti-lock fully cycling
        logic light_cat;       // Light goods vehicle category
        logic use_predict;     // Use predicted deceleration
    } bws_brake_s;

    typedef struct packed {
        logic red;
        logic yellow;
        logic trl_yellow;
        logic trl_red;
        logic stop;
        logic emergency;
    } bws_out_s;
endpackage
`default_nettype wire
